/* bench/instruction_execute_subset_tb_top.sv */
// self-checking testbench for the instruction execute core
`default_nettype none
`define CHK(g, e) check(g, e)
module instruction_execute_subset_tb_top
   import ies_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic        sys_clk;
   logic        rst;
   logic        clkEn;
   logic [7:0]  awAddr;
   logic        awValid;
   logic        awReady;
   logic [31:0] wData;
   logic [3:0]  wStrb;
   logic        wValid;
   logic        wReady;
   logic [1:0]  bResp;
   logic        bValid;
   logic        bReady;
   logic [7:0]  arAddr;
   logic        arValid;
   logic        arReady;
   logic [31:0] rData;
   logic [1:0]  rResp;
   logic        rValid;
   logic        rReady;
   logic        instrCycleTick;
   int          err_total;
   int          tests_run;
   int          gapCnt;
   logic        seenTick;
   logic [31:0] rd;
   logic [31:0] pc0;
   logic [1:0]  rs;
   logic        two;

   ies_core uut (
      .sys_clk        (sys_clk),
      .rst            (rst),
      .clkEn          (clkEn),
      .s_axi_awaddr   (awAddr),
      .s_axi_awvalid  (awValid),
      .s_axi_awready  (awReady),
      .s_axi_wdata    (wData),
      .s_axi_wstrb    (wStrb),
      .s_axi_wvalid   (wValid),
      .s_axi_wready   (wReady),
      .s_axi_bresp    (bResp),
      .s_axi_bvalid   (bValid),
      .s_axi_bready   (bReady),
      .s_axi_araddr   (arAddr),
      .s_axi_arvalid  (arValid),
      .s_axi_arready  (arReady),
      .s_axi_rdata    (rData),
      .s_axi_rresp    (rResp),
      .s_axi_rvalid   (rValid),
      .s_axi_rready   (rReady),
      .instrCycleTick (instrCycleTick)
   );

   // free-running 200 MHz clock
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic test_done;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask

   // one write: address and data offered together, each dropped once taken
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int   n;
      logic ta;
      logic tw;
      logic tb;
      n  = 0;
      tb = 1'b0;
      @(posedge sys_clk);
      awAddr  <= a;
      wData   <= d;
      awValid <= 1'b1;
      wValid  <= 1'b1;
      while (!tb && n < 200)
      begin
         @(negedge sys_clk);
         ta = awValid & awReady;
         tw = wValid & wReady;
         tb = bValid;
         r  = bResp;
         @(posedge sys_clk);
         if (ta)
            awValid <= 1'b0;
         if (tw)
            wValid <= 1'b0;
         n++;
      end
      if (!tb)
      begin
         err_total++;
         test_done();
      end
   endtask

   // one read: address held until taken, data taken with rvalid
   task automatic axiRd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int   n;
      logic ta;
      logic tr;
      n  = 0;
      tr = 1'b0;
      @(posedge sys_clk);
      arAddr  <= a;
      arValid <= 1'b1;
      while (!tr && n < 200)
      begin
         @(negedge sys_clk);
         ta = arValid & arReady;
         tr = rValid;
         d  = rData;
         r  = rResp;
         @(posedge sys_clk);
         if (ta)
            arValid <= 1'b0;
         n++;
      end
      if (!tr)
      begin
         err_total++;
         test_done();
      end
   endtask

   // issue one instruction and poll status only, so no 4-clock phase slips between samples
   task automatic exec(input logic [13:0] op, output logic saw2);
      int          n;
      logic [31:0] st;
      logic        busy;
      logic [1:0]  r;
      saw2 = 1'b0;
      busy = 1'b0;
      axiWr(REG_INSTR, {18'h0, op}, r);
      for (n = 0; n < 40; n++)
      begin
         axiRd(REG_STATUS, st, r);
         if (st[3] === 1'b1)
            saw2 = 1'b1;
         if (st[4] === 1'b1)
            busy = 1'b1;
         else if (busy)
            break;
      end
      if (n == 40)
      begin
         err_total++;
         test_done();
      end
   endtask

   // instruction cycle spacing seen at the tick output
   always @(negedge sys_clk)
   begin
      if (rst)
      begin
         gapCnt   <= 0;
         seenTick <= 1'b0;
      end
      else if (instrCycleTick === 1'b1)
      begin
         if (seenTick)
            `CHK(gapCnt, 32'd4);
         gapCnt   <= 1;
         seenTick <= 1'b1;
      end
      else
         gapCnt <= gapCnt + 1;
   end

   // main sequence
   initial
   begin
      err_total = 0;
      tests_run = 0;
      rst = 1'b1;
      clkEn = 1'b1;
      awAddr = 8'h00;
      awValid = 1'b0;
      wData = 32'h0;
      wStrb = 4'hF;
      wValid = 1'b0;
      bReady = 1'b1;
      arAddr = 8'h00;
      arValid = 1'b0;
      rReady = 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      // reset state and unmapped places
      axiRd(REG_STATUS, rd, rs);
      `CHK(rd[2:0], 32'h6);
      axiRd(REG_CTRL, rd, rs);
      `CHK(rd, 32'h0);
      axiRd(8'h40, rd, rs);
      `CHK(rs, RESP_SLVERR);
      axiWr(8'h44, 32'h0000_0055, rs);
      `CHK(rs, RESP_SLVERR);
      // complement to each destination, zero flag both ways
      exec(14'h0905, two);
      axiRd(REG_ACC, rd, rs);
      `CHK(rd[7:0], 32'hFF);
      axiRd(REG_STATUS, rd, rs);
      `CHK(rd[0], 32'h0);
      exec(14'h0985, two);
      exec(14'h0905, two);
      axiRd(REG_ACC, rd, rs);
      `CHK(rd[7:0], 32'h00);
      axiRd(REG_STATUS, rd, rs);
      `CHK(rd[0], 32'h1);
      // decrement: wrap from zero, back into f, and to zero
      exec(14'h0306, two);
      axiRd(REG_ACC, rd, rs);
      `CHK(rd[7:0], 32'hFF);
      exec(14'h0385, two);
      exec(14'h0985, two);
      exec(14'h0305, two);
      axiRd(REG_ACC, rd, rs);
      `CHK(rd[7:0], 32'h00);
      axiRd(REG_STATUS, rd, rs);
      `CHK(rd[0], 32'h1);
      // clear register, then clear accumulator
      exec(14'h0985, two);
      exec(14'h0185, two);
      axiRd(REG_STATUS, rd, rs);
      `CHK(rd[0], 32'h1);
      exec(14'h0905, two);
      axiRd(REG_ACC, rd, rs);
      `CHK(rd[7:0], 32'hFF);
      exec(14'h0100, two);
      axiRd(REG_ACC, rd, rs);
      `CHK(rd[7:0], 32'h00);
      axiRd(REG_STATUS, rd, rs);
      `CHK(rd[0], 32'h1);
      // bit test on top file address: clear bit continues, set bit skips
      axiRd(REG_PC, pc0, rs);
      exec(14'h1FFF, two);
      `CHK(two, 32'h0);
      axiRd(REG_PC, rd, rs);
      `CHK(rd[12:0], pc0[12:0] + 13'h1);
      axiRd(REG_STATUS, rd, rs);
      `CHK(rd[2:0], 32'h7);
      exec(14'h09FF, two);
      axiRd(REG_PC, pc0, rs);
      exec(14'h1FFF, two);
      `CHK(two, 32'h1);
      axiRd(REG_PC, rd, rs);
      `CHK(rd[12:0], pc0[12:0] + 13'h2);
      // call with latch bits, then plain return keeps flags
      exec(14'h0100, two);
      axiWr(REG_LATCH, 32'h0000_0018, rs);
      axiRd(REG_PC, pc0, rs);
      exec(14'h27FF, two);
      `CHK(two, 32'h1);
      axiRd(REG_PC, rd, rs);
      `CHK(rd[12:0], 32'h1FFF);
      exec(14'h0008, two);
      `CHK(two, 32'h1);
      axiRd(REG_PC, rd, rs);
      `CHK(rd[12:0], pc0[12:0] + 13'h1);
      axiRd(REG_STATUS, rd, rs);
      `CHK(rd[2:0], 32'h7);
      // call then literal return at the top literal value
      axiWr(REG_LATCH, 32'h0000_0000, rs);
      axiRd(REG_PC, pc0, rs);
      exec(14'h2123, two);
      axiRd(REG_PC, rd, rs);
      `CHK(rd[12:0], 32'h0123);
      exec(14'h34FF, two);
      `CHK(two, 32'h1);
      axiRd(REG_ACC, rd, rs);
      `CHK(rd[7:0], 32'hFF);
      axiRd(REG_PC, rd, rs);
      `CHK(rd[12:0], pc0[12:0] + 13'h1);
      // call then interrupt return sets the global enable
      axiWr(REG_INTCTL, 32'h0000_0000, rs);
      axiRd(REG_INTCTL, rd, rs);
      `CHK(rd[GIE_BIT], 32'h0);
      axiRd(REG_PC, pc0, rs);
      exec(14'h2040, two);
      exec(14'h0009, two);
      `CHK(two, 32'h1);
      axiRd(REG_INTCTL, rd, rs);
      `CHK(rd[GIE_BIT], 32'h1);
      axiRd(REG_PC, rd, rs);
      `CHK(rd[12:0], pc0[12:0] + 13'h1);
      // watchdog clear right after issue
      exec(14'h0064, two);
      axiRd(REG_WDT, rd, rs);
      `CHK(rd[7:0], 32'h00);
      axiRd(REG_STATUS, rd, rs);
      `CHK(rd[2:1], 32'h3);
      test_done();
   end
endmodule
`default_nettype wire

/* src/ies_core.sv */
// instruction execute core with AXI4-Lite control slave
`default_nettype none
module ies_core
   import ies_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst,
   input  wire logic        clkEn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic             instrCycleTick
);
   ies_file_if fif ();

   ies_reg_file u_file (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clkEn   (clkEn),
      .fp      (fif)
   );

   ies_state_t         state_q;
   logic [1:0]         qPhase_q;
   logic [INSTR_W-1:0] instr_q;
   logic               pending_q;
   logic [PC_W-1:0]    pc_q;
   logic [DATA_W-1:0]  acc_q;
   logic               zero_q;
   logic               timeOut_q;
   logic               powerDown_q;
   logic [DATA_W-1:0]  intCtl_q;
   logic [DATA_W-1:0]  latch_q;
   logic [WDT_W-1:0]   wdt_q;
   logic [PRE_W-1:0]   wdtPre_q;
   logic [PC_W-1:0]    stack_q [0:STACK_DEPTH-1];
   logic [2:0]         sp_q;
   logic               cycleEnd;

   // decoded operations
   logic isWdtClr, isRet, isRetIrq, isClrAcc, isClrReg, isDec, isCom, isBtss, isCall, isRetLit;
   logic [DATA_W-1:0] aluRes;
   logic              dstReg;
   logic [2:0]        bitSel;

   // merge write data under byte strobes
   function automatic logic [31:0] strobe_merge(input logic [31:0] old, input logic [31:0] nw,
                                                input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            r[i*8 +: 8] = nw[i*8 +: 8];
      return r;
   endfunction

   // divide by four: one instruction cycle per four clock periods
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         qPhase_q <= 2'h0;
      else if (clkEn)
         qPhase_q <= qPhase_q + 2'h1;
   end
   assign cycleEnd       = clkEn && (qPhase_q == Q_LAST);
   assign instrCycleTick = cycleEnd;

   // instruction decode
   always_comb
   begin
      isWdtClr = (instr_q == OP_WDTCLR);
      isRet    = (instr_q == OP_RETURN);
      isRetIrq = (instr_q == OP_RETIRQ);
      isClrAcc = (instr_q[13:7] == OP_CLRACC_HI);
      isClrReg = (instr_q[13:7] == OP_CLRREG_HI);
      isDec    = (instr_q[13:8] == OP_DEC_HI);
      isCom    = (instr_q[13:8] == OP_COM_HI);
      isBtss   = (instr_q[13:10] == OP_BTSS_HI);
      isCall   = (instr_q[13:11] == OP_CALL_HI);
      isRetLit = (instr_q[13:10] == OP_RETLIT_HI);
      dstReg   = instr_q[7];
      bitSel   = instr_q[9:7];
   end

   // register file access and alu
   assign fif.rdAddr = instr_q[FADDR_W-1:0];
   always_comb
   begin
      aluRes = ZERO8;
      if (isCom)
         aluRes = ~fif.rdData;
      else if (isDec)
         aluRes = fif.rdData - 8'h01;
   end
   logic execNow;
   assign execNow    = cycleEnd && (state_q == IES_EXEC);
   assign fif.wrEn   = execNow && (isClrReg || ((isCom || isDec) && dstReg));
   assign fif.wrAddr = instr_q[FADDR_W-1:0];
   assign fif.wrData = isClrReg ? ZERO8 : aluRes;

   // two-cycle and skip sequencing
   logic twoCycle;
   assign twoCycle = isCall || isRet || isRetIrq || isRetLit
                     || (isBtss && fif.rdData[bitSel]);

   logic startReq;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         state_q <= IES_IDLE;
      else if (cycleEnd)
      begin
         case (state_q)
            IES_IDLE:  if (pending_q) state_q <= IES_EXEC;
            IES_EXEC:  state_q <= twoCycle ? IES_FLUSH : IES_IDLE;
            IES_FLUSH: state_q <= IES_IDLE; // second cycle runs a no-op
            default:   state_q <= IES_IDLE;
         endcase
      end
   end

   // accumulator and zero flag
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         acc_q  <= ZERO8;
         zero_q <= 1'b0;
      end
      else if (execNow)
      begin
         if (isClrAcc)
         begin
            acc_q  <= ZERO8;
            zero_q <= 1'b1;
         end
         else if (isClrReg)
            zero_q <= 1'b1;
         else if (isCom || isDec)
         begin
            if (!dstReg)
               acc_q <= aluRes;
            zero_q <= (aluRes == ZERO8);
         end
         else if (isRetLit)
            acc_q <= instr_q[7:0];
      end
   end

   // program counter and stack
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         pc_q <= PC_RESET;
         sp_q <= 3'h0;
         for (int i = 0; i < STACK_DEPTH; i++)
            stack_q[i] <= PC_RESET;
      end
      else if (execNow)
      begin
         if (isCall)
         begin
            stack_q[sp_q] <= pc_q + 13'h0001;
            sp_q <= sp_q + 3'h1;
            pc_q <= {latch_q[LATCH_HI:LATCH_LO], instr_q[CALL_IMM_W-1:0]};
         end
         else if (isRet || isRetIrq || isRetLit)
         begin
            pc_q <= stack_q[sp_q - 3'h1];
            sp_q <= sp_q - 3'h1;
         end
         else
            pc_q <= pc_q + 13'h0001;
      end
      else if (cycleEnd && state_q == IES_FLUSH && isBtss)
         pc_q <= pc_q + 13'h0001; // skipped slot
   end

   // watchdog, time-out and power-down flags
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         wdt_q       <= ZERO8;
         wdtPre_q    <= 7'h00;
         timeOut_q   <= 1'b1;
         powerDown_q <= 1'b1;
      end
      else if (execNow && isWdtClr)
      begin
         wdt_q       <= ZERO8;
         wdtPre_q    <= 7'h00;
         timeOut_q   <= 1'b1;
         powerDown_q <= 1'b1;
      end
      else if (cycleEnd)
      begin
         wdtPre_q <= wdtPre_q + 7'h01;
         if (wdtPre_q == 7'h7F)
            wdt_q <= wdt_q + 8'h01;
      end
   end

   // AXI4-Lite write channel: take address and data in either order
   logic awHeld_q, wHeld_q;
   logic [7:0]  awAddr_q;
   logic [31:0] wData_q;
   logic [3:0]  wStrb_q;
   logic        doWrite;
   assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
   assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
   assign doWrite       = awHeld_q && wHeld_q && !s_axi_bvalid;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         awHeld_q     <= 1'b0;
         wHeld_q      <= 1'b0;
         awAddr_q     <= 8'h00;
         wData_q      <= 32'h0000_0000;
         wStrb_q      <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (clkEn)
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_q <= 1'b1;
            awAddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (doWrite)
         begin
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_q == REG_INSTR || awAddr_q == REG_INTCTL
                             || awAddr_q == REG_LATCH || awAddr_q == REG_CTRL)
                            ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // software-written registers and pending instruction
   logic [31:0] instrMerged;
   assign instrMerged = strobe_merge({18'h0, instr_q}, wData_q, wStrb_q);
   assign startReq    = clkEn && doWrite && awAddr_q == REG_INSTR;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         instr_q   <= 14'h0000;
         pending_q <= 1'b0;
         latch_q   <= ZERO8;
      end
      else if (clkEn)
      begin
         if (startReq && state_q == IES_IDLE)
         begin
            instr_q   <= instrMerged[INSTR_W-1:0];
            pending_q <= 1'b1;
         end
         else if (cycleEnd && state_q == IES_IDLE)
            pending_q <= 1'b0;
         if (doWrite && awAddr_q == REG_LATCH && wStrb_q[0])
            latch_q <= wData_q[7:0];
      end
   end

   // interrupt control register, hardware set of the enable wins
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         intCtl_q <= ZERO8;
      else if (clkEn)
      begin
         if (doWrite && awAddr_q == REG_INTCTL && wStrb_q[0])
            intCtl_q <= wData_q[7:0];
         if (execNow && isRetIrq)
            intCtl_q[GIE_BIT] <= 1'b1;
      end
   end

   // AXI4-Lite read channel
   logic [31:0] rdMux;
   logic        rdOk;
   always_comb
   begin
      rdOk  = 1'b1;
      rdMux = 32'h0000_0000;
      case (s_axi_araddr)
         REG_CTRL:   rdMux = {31'h0, pending_q};
         REG_INSTR:  rdMux = {18'h0, instr_q};
         REG_PC:     rdMux = {19'h0, pc_q};
         REG_ACC:    rdMux = {24'h0, acc_q};
         REG_STATUS: rdMux = {27'h0, state_q != IES_IDLE, state_q == IES_FLUSH,
                              timeOut_q, powerDown_q, zero_q};
         REG_INTCTL: rdMux = {24'h0, intCtl_q};
         REG_LATCH:  rdMux = {24'h0, latch_q};
         REG_WDT:    rdMux = {17'h0, wdtPre_q, wdt_q};
         default:    rdOk  = 1'b0;
      endcase
   end
   assign s_axi_arready = !s_axi_rvalid;
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end
      else if (clkEn)
      begin
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdMux;
            s_axi_rresp  <= rdOk ? RESP_OKAY : RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   // checks
   sequence execCall_s;
      execNow && isCall;
   endsequence
   sequence flushSlot_s;
      state_q == IES_FLUSH;
   endsequence

   tick_every_four_a: assert property (@(posedge sys_clk) disable iff (rst)
      cycleEnd |=> !cycleEnd[*3]) else $error("cycle tick spacing wrong");
   skip_two_cycles_a: assert property (@(posedge sys_clk) disable iff (rst)
      (execNow && isBtss && fif.rdData[bitSel]) |=> flushSlot_s)
      else $error("skip did not take second cycle");
   noskip_one_cycle_a: assert property (@(posedge sys_clk) disable iff (rst)
      (execNow && isBtss && !fif.rdData[bitSel]) |=> state_q == IES_IDLE && $stable(zero_q))
      else $error("clear bit test not single cycle");
   wdt_clear_flags_a: assert property (@(posedge sys_clk) disable iff (rst)
      (execNow && isWdtClr) |=> wdt_q == ZERO8 && timeOut_q && powerDown_q)
      else $error("watchdog clear wrong");
   call_target_a: assert property (@(posedge sys_clk) disable iff (rst)
      execCall_s |=> pc_q == {$past(latch_q[LATCH_HI:LATCH_LO]), $past(instr_q[10:0])}
      ##1 flushSlot_s) else $error("call target wrong");
   com_result_a: assert property (@(posedge sys_clk) disable iff (rst)
      (execNow && isCom && !dstReg) |=> acc_q == ~$past(fif.rdData)
      && zero_q == (acc_q == ZERO8)) else $error("complement wrong");
   clr_reg_a: assert property (@(posedge sys_clk) disable iff (rst)
      (execNow && isClrReg) |-> fif.wrEn && fif.wrData == ZERO8 ##1 zero_q)
      else $error("clear register wrong");
   dec_result_a: assert property (@(posedge sys_clk) disable iff (rst)
      (execNow && isDec && !dstReg) |=> acc_q == $past(fif.rdData) - 8'h01)
      else $error("decrement wrong");
   clr_acc_a: assert property (@(posedge sys_clk) disable iff (rst)
      (execNow && isClrAcc) |=> acc_q == ZERO8 && zero_q) else $error("clear acc wrong");
   irq_return_a: assert property (@(posedge sys_clk) disable iff (rst)
      (execNow && isRetIrq) |=> intCtl_q[GIE_BIT] and flushSlot_s)
      else $error("interrupt return wrong");
   lit_return_a: assert property (@(posedge sys_clk) disable iff (rst)
      (execNow && isRetLit) |=> acc_q == $past(instr_q[7:0]))
      else $error("literal return wrong");
   ret_flags_a: assert property (@(posedge sys_clk) disable iff (rst)
      (execNow && isRet) |=> ($stable(zero_q) && $stable(timeOut_q)) and flushSlot_s)
      else $error("return changed flags");
endmodule
`default_nettype wire

/* src/ies_file_if.sv */
// interface carrying register file port between core and file
`default_nettype none
interface ies_file_if;
   import ies_pkg::*;
   logic [FADDR_W-1:0] rdAddr;
   logic [DATA_W-1:0]  rdData;
   logic               wrEn;
   logic [FADDR_W-1:0] wrAddr;
   logic [DATA_W-1:0]  wrData;
   modport core (output rdAddr, output wrEn, output wrAddr, output wrData, input rdData);
   modport file (input rdAddr, input wrEn, input wrAddr, input wrData, output rdData);
endinterface
`default_nettype wire

/* src/ies_pkg.sv */
// package of constants and types for the instruction execute subset
`default_nettype none
// Behaviour
// - a bit-test-skip whose tested bit of register f is one discards the next instruction and runs a no-op instead, taking two cycles, with f up to 127.
// - the watchdog-clear operation zeroes the watchdog counter and its prescaler and sets the time-out and power-down flags to one.
// - a call pushes the incremented program counter, loads the 11-bit immediate into bits 10:0 and latch bits 4:3 into bits 12:11, taking two cycles.
// - complement inverts register f, writes the accumulator when the destination bit is 0 or register f when 1, and updates the zero flag.
// - clear-register writes zero into register f and sets the zero flag.
// - decrement subtracts one from register f, writes the accumulator when the destination bit is 0 or register f when 1, and updates the zero flag.
// - clear-accumulator loads zero into the accumulator and sets the zero flag.
// - interrupt return pops the stack head into the program counter and sets the global interrupt enable, bit 7 of the interrupt control register, taking two cycles.
// - literal return loads its 8-bit immediate into the accumulator and the program counter from the stack head, taking two cycles.
// - subroutine return pops the stack into the program counter, takes two cycles and leaves all flags unchanged.
// - each instruction cycle spans exactly four oscillator clock periods.
package ies_pkg;
   localparam int          DATA_W        = 8;
   localparam int          PC_W          = 13;
   localparam int          FADDR_W       = 7;
   localparam int          INSTR_W       = 14;
   localparam int          STACK_DEPTH   = 8;
   localparam int          WDT_W         = 8;
   localparam int          PRE_W         = 7;
   localparam int          QCLK_PER_CYC  = 4;
   localparam logic [1:0]  Q_LAST        = 2'h3;
   localparam int          GIE_BIT       = 7;
   localparam int          LATCH_LO      = 3;
   localparam int          LATCH_HI      = 4;
   localparam int          CALL_IMM_W    = 11;
   localparam logic [PC_W-1:0] PC_RESET  = 13'h0000;
   localparam logic [DATA_W-1:0] ZERO8   = 8'h00;
   // opcode patterns (14-bit)
   localparam logic [13:0] OP_WDTCLR     = 14'h0064;
   localparam logic [13:0] OP_RETURN     = 14'h0008;
   localparam logic [13:0] OP_RETIRQ     = 14'h0009;
   localparam logic [6:0]  OP_CLRACC_HI  = 7'h02; // bits 13:7 with bits 6:0 don't care
   localparam logic [6:0]  OP_CLRREG_HI  = 7'h03;
   localparam logic [5:0]  OP_DEC_HI     = 6'h03;
   localparam logic [5:0]  OP_COM_HI     = 6'h09;
   localparam logic [3:0]  OP_BTSS_HI    = 4'h7;
   localparam logic [2:0]  OP_CALL_HI    = 3'h4;
   localparam logic [3:0]  OP_RETLIT_HI  = 4'hD;
   // AXI4-Lite register map (byte addresses)
   localparam logic [7:0]  REG_CTRL      = 8'h00; // bit0 pending instruction (read only, writes ignored)
   localparam logic [7:0]  REG_INSTR     = 8'h04; // instruction to execute
   localparam logic [7:0]  REG_PC        = 8'h08;
   localparam logic [7:0]  REG_ACC       = 8'h0C;
   localparam logic [7:0]  REG_STATUS    = 8'h10; // 0 zero,1 pd,2 to,3 second cycle,4 busy
   localparam logic [7:0]  REG_INTCTL    = 8'h14;
   localparam logic [7:0]  REG_LATCH     = 8'h18;
   localparam logic [7:0]  REG_WDT       = 8'h1C; // 7:0 counter, 14:8 prescaler
   localparam logic [7:0]  REG_FILEWIN   = 8'h20; // 0x20..0x3C not decoded, reads there return SLVERR
   localparam logic [1:0]  RESP_OKAY     = 2'h0;
   localparam logic [1:0]  RESP_SLVERR   = 2'h2;
   typedef enum logic [1:0] {
      IES_IDLE  = 2'b00,
      IES_EXEC  = 2'b01,
      IES_FLUSH = 2'b10
   } ies_state_t;
endpackage
`default_nettype wire

/* src/ies_reg_file.sv */
// data register file of 128 bytes
`default_nettype none
module ies_reg_file
   import ies_pkg::*;
(
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic clkEn,
   ies_file_if.file  fp
);
   logic [DATA_W-1:0] mem [0:(1<<FADDR_W)-1];

   // combinational read port
   assign fp.rdData = mem[fp.rdAddr];

   // write port, cleared under reset
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         for (int i = 0; i < (1<<FADDR_W); i++)
            mem[i] <= ZERO8;
      end
      else if (clkEn && fp.wrEn)
         mem[fp.wrAddr] <= fp.wrData;
   end
endmodule
`default_nettype wire
